// *** pkg/t1_perf_pkg.sv ***
// constants and types for the T1 performance counters and interrupt masks
package t1_perf_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_LINE_HIGH = 8'h23;
  localparam logic [7:0] ADDR_LINE_LOW = 8'h24;
  localparam logic [7:0] ADDR_PATH_HIGH = 8'h25;
  localparam logic [7:0] ADDR_PATH_LOW = 8'h26;
  localparam logic [7:0] ADDR_MASK_SECOND = 8'h6F;
  localparam logic [7:0] ADDR_MASK_FIRST = 8'h7F;
  localparam logic [7:0] ADDR_STATUS_FIRST = 8'h70;
  localparam logic [7:0] ADDR_STATUS_SECOND = 8'h71;
  localparam logic [7:0] ADDR_CONFIG = 8'h72;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CFG_INTERVAL_BIT = 0;
  localparam int CFG_ZERO_SUB_BIT = 1;
  localparam int CFG_FRAMING_BIT = 2;
  localparam int CFG_ZERO_RUNS_BIT = 3;
  localparam int CFG_FS_COUNT_BIT = 4;
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'h1F;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int SECOND_TICK_BIT = 5;
  localparam int LINE_WIDTH = 16;
  localparam int PATH_WIDTH = 12;
  localparam logic [15:0] LINE_MAX = 16'hFFFF;
  localparam logic [15:0] PATH_MAX = 16'h0FFF;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  // ****************************************
  // interval timing, in received line bits
  // ****************************************
  localparam int LINE_RATE_BPS = 1544000;
  localparam int BITS_PER_MS = LINE_RATE_BPS / 1000;
  localparam int SEC_SHORT_MS = 999;
  localparam int SEC_LONG_MS = 1002;
  localparam int FAST_INTERVAL_MS = 42;
  localparam int SEC_SHORT_BITS = SEC_SHORT_MS * BITS_PER_MS;
  localparam int SEC_LONG_BITS = SEC_LONG_MS * BITS_PER_MS;
  localparam int FAST_INTERVAL_BITS = FAST_INTERVAL_MS * BITS_PER_MS;
  localparam int TIMER_WIDTH = 21;

  typedef enum {PHASE_FIRST, PHASE_SECOND, PHASE_LONG} sec_phase_t;

endpackage

// *** rtl/one_second_timer.sv ***
// interval timer: one-second tick over a 3 s cycle and a 42 ms tick
`timescale 1ns/1ns
module one_second_timer
  import t1_perf_pkg::*;
#(
  parameter int SHORT_SEC_BITS = SEC_SHORT_BITS,
  parameter int LONG_SEC_BITS = SEC_LONG_BITS,
  parameter int FAST_BITS = FAST_INTERVAL_BITS
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // one pulse per received line bit
  input wire logic line_bit,
  // interval ticks
  output logic second_tick,
  output logic fast_tick
);

  logic [TIMER_WIDTH-1:0] sec_count;
  logic [TIMER_WIDTH-1:0] sec_limit;
  logic [TIMER_WIDTH-1:0] fast_count;
  sec_phase_t phase;

  // two short seconds then a long one keep the 3 s cycle exact
  always_comb
  begin
    sec_limit = (phase == PHASE_LONG) ? TIMER_WIDTH'(LONG_SEC_BITS - 1) : TIMER_WIDTH'(SHORT_SEC_BITS - 1);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sec_count <= '0;
      phase <= PHASE_FIRST;
      second_tick <= 1'b0;
    end
    else
    begin
      second_tick <= 1'b0;
      if (line_bit)
      begin
        if (sec_count == sec_limit)
        begin
          sec_count <= '0;
          second_tick <= 1'b1;
          unique case (phase)
            PHASE_FIRST: phase <= PHASE_SECOND;
            PHASE_SECOND: phase <= PHASE_LONG;
            PHASE_LONG: phase <= PHASE_FIRST;
          endcase
        end
        else
          sec_count <= sec_count + 1'h1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      fast_count <= '0;
      fast_tick <= 1'b0;
    end
    else
    begin
      fast_tick <= 1'b0;
      if (line_bit)
      begin
        if (fast_count == TIMER_WIDTH'(FAST_BITS - 1))
        begin
          fast_count <= '0;
          fast_tick <= 1'b1;
        end
        else
          fast_count <= fast_count + 1'h1;
      end
    end
  end

  chk_long_phase_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
    (phase == PHASE_LONG && line_bit && sec_count == sec_limit) |=> (second_tick && phase == PHASE_FIRST))
    else $error("long second not followed by first phase");

endmodule

// *** rtl/t1_perf_counters.sv ***
// T1 receive error counters, interval latching and interrupt masks
`timescale 1ns/1ns
module t1_perf_counters
  import t1_perf_pkg::*;
#(
  parameter int SHORT_SEC_BITS = SEC_SHORT_BITS,
  parameter int LONG_SEC_BITS = SEC_LONG_BITS,
  parameter int FAST_BITS = FAST_INTERVAL_BITS
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // receive line events
  input wire logic line_bit,
  input wire logic bpv_event,
  input wire logic bpv_in_codeword,
  input wire logic zero_run_16,
  input wire logic zero_run_8,
  input wire logic crc6_error,
  input wire logic ft_error,
  input wire logic fs_error,
  input wire logic receive_sync_lost,
  // status conditions, one pulse per occurrence
  input wire logic [7:0] first_status_events,
  input wire logic [7:0] second_status_events,
  // interrupt and timer
  output logic irq,
  output logic one_second_tick
);

  // ****************************************
  // saturating arithmetic
  // ****************************************
  function automatic logic [15:0] sat_add(
    input logic [15:0] value,
    input logic [1:0] step,
    input logic [15:0] limit
  );
    logic [16:0] sum;
    sum = {1'b0, value} + {15'h0000, step};
    if (sum > {1'b0, limit})
      sat_add = limit;
    else
      sat_add = sum[15:0];
  endfunction

  function automatic logic [1:0] add_bits(input logic a, input logic b);
    add_bits = {1'b0, a} + {1'b0, b};
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] mask_first;
  logic [7:0] mask_second;
  logic [7:0] status_first;
  logic [7:0] status_second;
  logic [7:0] config_bits;
  logic [LINE_WIDTH-1:0] line_acc;
  logic [LINE_WIDTH-1:0] line_latched;
  logic [PATH_WIDTH-1:0] path_acc;
  logic [PATH_WIDTH-1:0] path_latched;
  logic [LINE_WIDTH-1:0] next_line_total;
  logic [PATH_WIDTH-1:0] next_path_total;
  logic [1:0] line_step;
  logic [1:0] path_step;
  logic [7:0] tick_vec;
  logic second_tick;
  logic fast_tick;
  logic interval_update;
  logic interval_sel;
  logic zero_sub;
  logic esf_mode;
  logic zero_runs;
  logic fs_count;
  logic bpv_counts;
  logic zero_counts;
  logic rd_status_first;
  logic rd_status_second;
  logic irq_pending;

  // ****************************************
  // interval timer
  // ****************************************
  one_second_timer #(
    .SHORT_SEC_BITS(SHORT_SEC_BITS),
    .LONG_SEC_BITS(LONG_SEC_BITS),
    .FAST_BITS(FAST_BITS)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .line_bit(line_bit),
    .second_tick(second_tick),
    .fast_tick(fast_tick)
  );

  assign one_second_tick = second_tick;
  assign interval_sel = config_bits[CFG_INTERVAL_BIT];
  assign zero_sub = config_bits[CFG_ZERO_SUB_BIT];
  assign esf_mode = config_bits[CFG_FRAMING_BIT];
  assign zero_runs = config_bits[CFG_ZERO_RUNS_BIT];
  assign fs_count = config_bits[CFG_FS_COUNT_BIT];
  assign interval_update = interval_sel ? fast_tick : second_tick;

  // ****************************************
  // event selection
  // ****************************************
  always_comb
  begin
    // substituted code words carry intentional violations
    bpv_counts = bpv_event && !(zero_sub && bpv_in_codeword);
    zero_counts = zero_runs && (zero_sub ? zero_run_8 : zero_run_16);
    line_step = add_bits(bpv_counts, zero_counts);
  end

  always_comb
  begin
    if (receive_sync_lost)
      path_step = 2'h0;
    else if (esf_mode)
      path_step = add_bits(crc6_error, 1'b0);
    else
      path_step = add_bits(ft_error, fs_count && fs_error);
  end

  // the latched total includes events of the update cycle itself
  always_comb
  begin
    next_line_total = sat_add(line_acc, line_step, LINE_MAX);
    next_path_total = PATH_WIDTH'(sat_add({NIBBLE_ZERO, path_acc}, path_step, PATH_MAX));
  end

  // ****************************************
  // accumulators and latched counts
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      line_acc <= '0;
    else if (interval_update)
      line_acc <= '0;
    else
      line_acc <= next_line_total;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      path_acc <= '0;
    else if (interval_update)
      path_acc <= '0;
    else
      path_acc <= next_path_total;
  end

  // overwritten each interval; software must read in time
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      line_latched <= '0;
      path_latched <= '0;
    end
    else if (interval_update)
    begin
      line_latched <= next_line_total;
      path_latched <= next_path_total;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      mask_first <= MASK_RESET;
      mask_second <= MASK_RESET;
      config_bits <= CONFIG_RESET;
    end
    else if (reg_write)
    begin
      if (reg_addr == ADDR_MASK_FIRST)
        mask_first <= reg_wdata;
      if (reg_addr == ADDR_MASK_SECOND)
        mask_second <= reg_wdata;
      if (reg_addr == ADDR_CONFIG)
        config_bits <= reg_wdata & CONFIG_WRITE_MASK;
    end
  end

  // ****************************************
  // sticky status and interrupt
  // ****************************************
  always_comb
  begin
    tick_vec = '0;
    tick_vec[SECOND_TICK_BIT] = second_tick;
    rd_status_first = reg_read && (reg_addr == ADDR_STATUS_FIRST);
    rd_status_second = reg_read && (reg_addr == ADDR_STATUS_SECOND);
  end

  // a new event in the clearing read's cycle stays set
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      status_first <= STATUS_RESET;
      status_second <= STATUS_RESET;
    end
    else
    begin
      status_first <= (status_first & ~{8{rd_status_first}}) | first_status_events;
      status_second <= (status_second & ~{8{rd_status_second}}) | second_status_events | tick_vec;
    end
  end

  assign irq_pending = |(status_first & mask_first) || |(status_second & mask_second);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= irq_pending;
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else if (reg_read)
    begin
      case (reg_addr)
        ADDR_LINE_HIGH: reg_rdata <= line_latched[15:8];
        ADDR_LINE_LOW: reg_rdata <= line_latched[7:0];
        // upper nibble belongs to a counter not built here
        ADDR_PATH_HIGH: reg_rdata <= {NIBBLE_ZERO, path_latched[11:8]};
        ADDR_PATH_LOW: reg_rdata <= path_latched[7:0];
        ADDR_MASK_FIRST: reg_rdata <= mask_first;
        ADDR_MASK_SECOND: reg_rdata <= mask_second;
        ADDR_STATUS_FIRST: reg_rdata <= status_first;
        ADDR_STATUS_SECOND: reg_rdata <= status_second;
        ADDR_CONFIG: reg_rdata <= config_bits;
        default: reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_write(logic [7:0] addr);
    reg_write && reg_addr == addr;
  endsequence

  sequence s_read(logic [7:0] addr);
    reg_read && reg_addr == addr;
  endsequence

  sequence s_quiet;
    !interval_update;
  endsequence

  chk_mask_first_write: assert property (s_write(ADDR_MASK_FIRST) |=>
    mask_first == $past(reg_wdata))
    else $error("first mask not written");

  chk_mask_second_readback: assert property (s_write(ADDR_MASK_SECOND) ##1
    s_read(ADDR_MASK_SECOND) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("second mask readback wrong");

  chk_fast_interval_only: assert property ((interval_sel && second_tick && !fast_tick)
    |=> $stable(line_latched) && $stable(path_latched))
    else $error("counts latched on second tick in fast mode");

  chk_second_interval_only: assert property ((!interval_sel && fast_tick && !second_tick)
    |=> $stable(line_latched))
    else $error("counts latched on fast tick in second mode");

  chk_latched_hold: assert property (s_quiet |=> $stable(line_latched) && $stable(path_latched))
    else $error("latched counts changed between intervals");

  chk_line_saturate: assert property ((line_acc == LINE_MAX) and s_quiet |=> line_acc == LINE_MAX)
    else $error("line counter wrapped");

  chk_path_saturate: assert property ((path_acc == PATH_MAX[PATH_WIDTH-1:0]) and s_quiet
    |=> path_acc == PATH_MAX[PATH_WIDTH-1:0])
    else $error("path counter wrapped");

  chk_line_high_byte: assert property (s_read(ADDR_LINE_HIGH) and s_quiet
    |=> reg_rdata == line_latched[15:8])
    else $error("line high byte wrong");

  chk_line_low_byte: assert property (s_read(ADDR_LINE_LOW) and s_quiet
    |=> reg_rdata == line_latched[7:0])
    else $error("line low byte wrong");

  chk_line_sync_loss: assert property ((receive_sync_lost && bpv_event && !bpv_in_codeword
    && !zero_run_8 && !zero_run_16 && line_acc != LINE_MAX) and s_quiet
    |=> line_acc == $past(line_acc) + 1'h1)
    else $error("line count missed event during sync loss");

  chk_codeword_excluded: assert property ((zero_sub && bpv_event && bpv_in_codeword
    && !zero_runs) and s_quiet |=> $stable(line_acc))
    else $error("substituted code word counted");

  chk_zero_run_select: assert property ((zero_runs && zero_sub && zero_run_16 && !zero_run_8
    && !bpv_event) and s_quiet |=> $stable(line_acc))
    else $error("16-zero run counted with substitution on");

  chk_esf_crc_count: assert property ((esf_mode && crc6_error && !receive_sync_lost
    && path_acc != PATH_MAX[PATH_WIDTH-1:0]) and s_quiet |=> path_acc == $past(path_acc) + 1'h1)
    else $error("CRC6 error not counted");

  chk_d4_fs_gated: assert property ((!esf_mode && !fs_count && fs_error && !ft_error)
    and s_quiet |=> $stable(path_acc))
    else $error("Fs error counted while disabled");

  chk_path_sync_loss: assert property (receive_sync_lost and s_quiet |=> $stable(path_acc))
    else $error("path counter ran during sync loss");

  chk_path_high_nibble: assert property (s_read(ADDR_PATH_HIGH) and s_quiet
    |=> reg_rdata == {NIBBLE_ZERO, path_latched[11:8]})
    else $error("path high register wrong");

  chk_irq_follows: assert property (irq_pending |=> irq)
    else $error("interrupt not raised");

  chk_irq_drops: assert property (!irq_pending && !$past(irq_pending) |-> !irq)
    else $error("interrupt stuck without enabled status");

  chk_update_clears: assert property (interval_update |=> line_acc == '0 && path_acc == '0
    && line_latched == $past(next_line_total))
    else $error("accumulator not cleared on update");

  chk_status_set_wins: assert property (rd_status_first && first_status_events != '0
    |=> (status_first & $past(first_status_events)) == $past(first_status_events))
    else $error("event lost on clearing read");

endmodule

// *** verif/line_source.sv ***
// receive line model: bit pulses on request, with a count of bits sent
`timescale 1ns/1ns
module line_source
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // request from the bench
  input wire logic run,
  // line side
  output logic line_bit,
  output int unsigned sent
);
  // bits only on request, so interval edges can be placed exactly
  assign line_bit = run;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sent <= 0;
    else if (line_bit)
      sent <= sent + 1;
  end
endmodule

// *** verif/tb.sv ***
// self-checking bench for the T1 error counters and interrupt masks
`timescale 1ns/1ns
module tb;
  import t1_perf_pkg::*;
  localparam int SHORT_N = 20;
  localparam int LONG_N = 23;
  localparam int FAST_N = 5;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic run = 1'b0;
  logic line_bit;
  int unsigned sent;
  // bpv, code word, zero16, zero8, crc6, ft, fs
  logic [6:0] ev = 7'h00;
  logic sync_lost = 1'b0;
  logic [7:0] st1 = 8'h00;
  logic [7:0] st2 = 8'h00;
  logic irq;
  logic one_second_tick;
  int err_total = 0;
  int n_compared = 0;
  int tick_n = 0;
  int tick_k[$];
  int tick_at[$];
  logic grab = 1'b0;
  logic [7:0] cfg;
  logic [15:0] want;
  int n;

  always #5 core_clk = ~core_clk;

  line_source u_line_source (.core_clk(core_clk), .rst_n(rst_n), .run(run), .line_bit(line_bit), .sent(sent));

  t1_perf_counters #(.SHORT_SEC_BITS(SHORT_N), .LONG_SEC_BITS(LONG_N), .FAST_BITS(FAST_N)) u_t1_perf_counters (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .line_bit(line_bit),
    .bpv_event(ev[6]), .bpv_in_codeword(ev[5]), .zero_run_16(ev[4]), .zero_run_8(ev[3]),
    .crc6_error(ev[2]), .ft_error(ev[1]), .fs_error(ev[0]), .receive_sync_lost(sync_lost),
    .first_status_events(st1), .second_status_events(st2), .irq(irq), .one_second_tick(one_second_tick));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    check({8'h00, reg_rdata}, {8'h00, exp}, what);
  endtask

  task automatic pulse(input logic [6:0] e, input logic [7:0] s1, input logic [7:0] s2);
    @(posedge core_clk);
    ev <= e;
    st1 <= s1;
    st2 <= s2;
    @(posedge core_clk);
    ev <= 7'h00;
    st1 <= 8'h00;
    st2 <= 8'h00;
  endtask

  // line runs only until the next second boundary, then counts settle
  task automatic wait_tick();
    int i;
    @(posedge core_clk);
    run <= 1'b1;
    for (i = 0; i < 100 && one_second_tick !== 1'b1; i++)
      @(posedge core_clk);
    run <= 1'b0;
    check({15'h0000, one_second_tick}, 16'h0001, "second tick");
    repeat (3) @(posedge core_clk);
  endtask

  task automatic irq_chk(input logic exp, input string what);
    repeat (2) @(posedge core_clk);
    #1;
    check({15'h0000, irq}, {15'h0000, exp}, what);
  endtask

  always @(posedge core_clk)
  begin
    if (one_second_tick === 1'b1)
    begin
      tick_n++;
      if (grab)
      begin
        tick_k.push_back(tick_n);
        tick_at.push_back(sent);
      end
    end
  end

  initial
  begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(ADDR_MASK_FIRST, MASK_RESET, "first mask reset");
    rd_chk(ADDR_MASK_SECOND, MASK_RESET, "second mask reset");
    rd_chk(ADDR_LINE_LOW, 8'h00, "line count reset");
    rd_chk(8'h50, 8'h00, "unmapped read");
    wr(ADDR_MASK_FIRST, 8'hA5);
    wr(ADDR_MASK_SECOND, 8'h5A);
    wr(ADDR_LINE_HIGH, 8'hFF);
    rd_chk(ADDR_MASK_FIRST, 8'hA5, "first mask");
    rd_chk(ADDR_MASK_SECOND, 8'h5A, "second mask");
    rd_chk(ADDR_LINE_HIGH, 8'h00, "line count read only");
    @(posedge core_clk);
    #1;
    check({8'h00, reg_rdata}, 16'h0000, "read data after its cycle");
    // write then read back with no gap between the strobes
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= ADDR_MASK_SECOND;
    reg_wdata <= 8'h3C;
    @(posedge core_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    check({8'h00, reg_rdata}, 16'h003C, "back to back readback");
    // each mask bit alone: others masked, then own event raises irq
    for (int r = 0; r < 2; r++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        wr(r ? ADDR_MASK_SECOND : ADDR_MASK_FIRST, 8'h01 << i);
        wr(r ? ADDR_MASK_FIRST : ADDR_MASK_SECOND, 8'h00);
        pulse(7'h00, r ? 8'h00 : ~(8'h01 << i), r ? ~(8'h01 << i) : 8'h00);
        irq_chk(1'b0, "masked events");
        rd_chk(r ? ADDR_STATUS_SECOND : ADDR_STATUS_FIRST, ~(8'h01 << i), "status masked");
        pulse(7'h00, r ? 8'h00 : 8'h01 << i, r ? 8'h01 << i : 8'h00);
        irq_chk(1'b1, "enabled event");
        rd_chk(r ? ADDR_STATUS_SECOND : ADDR_STATUS_FIRST, 8'h01 << i, "status enabled");
        irq_chk(1'b0, "irq after clear");
      end
    end
    wr(ADDR_MASK_SECOND, 8'h00);
    // an event in the clearing read's cycle stays set
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= ADDR_STATUS_FIRST;
    st1 <= 8'h81;
    @(posedge core_clk);
    reg_read <= 1'b0;
    st1 <= 8'h00;
    #1;
    check({8'h00, reg_rdata}, 16'h0000, "status before set wins");
    rd_chk(ADDR_STATUS_FIRST, 8'h81, "set wins over clear");
    // line count for all four zero settings, sync lost throughout
    for (int m = 0; m < 4; m++)
    begin
      cfg = 8'h00;
      cfg[CFG_ZERO_SUB_BIT] = m[0];
      cfg[CFG_ZERO_RUNS_BIT] = m[1];
      wr(ADDR_CONFIG, cfg);
      sync_lost <= 1'b1;
      pulse(7'b1000000, 8'h00, 8'h00);
      pulse(7'b1100000, 8'h00, 8'h00);
      pulse(7'b0010000, 8'h00, 8'h00);
      pulse(7'b0001000, 8'h00, 8'h00);
      pulse(7'b0000010, 8'h00, 8'h00);
      wait_tick();
      sync_lost <= 1'b0;
      want = 16'd1 + (m[0] ? 16'd0 : 16'd1) + ((m[1] && !m[0]) ? 16'd1 : 16'd0) + ((m[1] && m[0]) ? 16'd1 : 16'd0);
      rd_chk(ADDR_LINE_HIGH, want[15:8], "line high");
      rd_chk(ADDR_LINE_LOW, want[7:0], "line low");
      rd_chk(ADDR_PATH_LOW, 8'h00, "path during sync loss");
    end
    wait_tick();
    rd_chk(ADDR_LINE_LOW, 8'h00, "previous interval only");
    // path count: ESF, D4, D4 with Fs
    for (int p = 0; p < 3; p++)
    begin
      cfg = 8'h00;
      cfg[CFG_FRAMING_BIT] = (p == 0);
      cfg[CFG_FS_COUNT_BIT] = (p == 2);
      wr(ADDR_CONFIG, cfg);
      pulse(7'b0000100, 8'h00, 8'h00);
      pulse(7'b0000100, 8'h00, 8'h00);
      pulse(7'b0000010, 8'h00, 8'h00);
      pulse(7'b0000001, 8'h00, 8'h00);
      wait_tick();
      rd_chk(ADDR_PATH_HIGH, 8'h00, "path high");
      rd_chk(ADDR_PATH_LOW, (p == 1) ? 8'h01 : 8'h02, "path count");
    end
    // continuous line: spacing of second ticks
    @(posedge core_clk);
    grab <= 1'b1;
    run <= 1'b1;
    repeat (140) @(posedge core_clk);
    run <= 1'b0;
    grab <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(16'(tick_k.size()), 16'd6, "ticks in window");
    for (int t = 1; t < tick_k.size(); t++)
      check(16'(tick_at[t] - tick_at[t - 1]), (tick_k[t] % 3 == 0) ? 16'(LONG_N) : 16'(SHORT_N), "tick spacing");
    rd_chk(ADDR_STATUS_SECOND, 8'h01 << SECOND_TICK_BIT, "second status bit");
    // saturation in one interval
    cfg = 8'h00;
    cfg[CFG_ZERO_RUNS_BIT] = 1'b1;
    wr(ADDR_CONFIG, cfg);
    repeat (33000) pulse(7'b1010010, 8'h00, 8'h00);
    wait_tick();
    rd_chk(ADDR_LINE_HIGH, 8'hFF, "line saturated high");
    rd_chk(ADDR_LINE_LOW, 8'hFF, "line saturated low");
    rd_chk(ADDR_PATH_HIGH, 8'h0F, "path saturated high");
    rd_chk(ADDR_PATH_LOW, 8'hFF, "path saturated low");
    // short interval
    wr(ADDR_CONFIG, 8'h01);
    repeat (3) pulse(7'b1000000, 8'h00, 8'h00);
    for (int f = 0; f < 2; f++)
    begin
      n = FAST_N - (sent % FAST_N);
      @(posedge core_clk);
      run <= 1'b1;
      repeat (n) @(posedge core_clk);
      run <= 1'b0;
      repeat (3) @(posedge core_clk);
      rd_chk(ADDR_LINE_LOW, f ? 8'h00 : 8'h03, "short interval count");
    end
    // a long second ends between fast ticks: it must not latch the pending event
    for (int s = 0; s < 2; s++)
    begin
      @(posedge core_clk);
      run <= 1'b1;
      repeat (s ? 2 : 51) @(posedge core_clk);
      run <= 1'b0;
      if (!s)
        pulse(7'b1000000, 8'h00, 8'h00);
    end
    repeat (3) @(posedge core_clk);
    rd_chk(ADDR_LINE_LOW, 8'h00, "second tick ignored in fast mode");
    test_done();
  end
endmodule
